// File: verilog/apsc_ctrl.sv
// Power-state controller: active, power-down and stand-by sequencing
// ==========================================================
// Behaviour
// - Exactly one of three states at all times
// - Power-down: no conversions, registers kept, power cut
// - Stand-by: no conversions, fast return to active
// - Register write requests the selected state
// - Register read returns the actual state
// - Readback matches request after 15 us latency
// - Requests during pending latency are rejected
// - No direct power-down to stand-by move
`timescale 1ns/1ps

module apsc_ctrl (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Power state register write
	input wire logic wr_en,
	input wire apsc_pkg::apsc_state_t wr_state,
	// Power state register readback and status
	output apsc_pkg::apsc_state_t rd_state,
	output logic busy,
	output logic req_rejected,
	// Power controls toward the analog core
	output logic conv_en,
	output logic core_pwr_en,
	output logic bias_pwr_en
);

	// ==========================================================
	// State
	apsc_pkg::apsc_state_t cur_q, cur_d;
	apsc_pkg::apsc_state_t tgt_q, tgt_d;
	logic [apsc_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic pend_q, pend_d;
	logic rej_q, rej_d;
	logic conv_q, conv_d, core_q, core_d, bias_q, bias_d;
	logic legal;

	// Next-state computation; the latency counter doubles as the reject window
	always_comb begin
		cur_d = cur_q;
		tgt_d = tgt_q;
		cnt_d = cnt_q;
		pend_d = pend_q;
		rej_d = 1'b0;
		// Only the three codes and no power-down to stand-by jump
		legal = (wr_state == apsc_pkg::APSC_ACTIVE) || (wr_state == apsc_pkg::APSC_PWRDN) ||
			((wr_state == apsc_pkg::APSC_STBY) && (cur_q != apsc_pkg::APSC_PWRDN));
		if (pend_q) begin
			if (cnt_q == apsc_pkg::CNT_RST + 10'h001) begin
				cur_d = tgt_q;
				pend_d = 1'b0;
				cnt_d = apsc_pkg::CNT_RST;
			end else begin
				cnt_d = cnt_q - 10'h001;
			end
		end
		if (wr_en) begin
			if (pend_q || !legal) begin
				rej_d = 1'b1;
			end else begin
				tgt_d = wr_state;
				pend_d = 1'b1;
				cnt_d = apsc_pkg::LAT_CNT;
			end
		end
		// Stand-by keeps bias up so the return to active is quick
		conv_d = (cur_d == apsc_pkg::APSC_ACTIVE);
		core_d = (cur_d == apsc_pkg::APSC_ACTIVE);
		bias_d = (cur_d != apsc_pkg::APSC_PWRDN);
	end

	// Registers; clock enable low freezes everything
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_q <= apsc_pkg::APSC_ACTIVE;
			tgt_q <= apsc_pkg::APSC_ACTIVE;
			cnt_q <= apsc_pkg::CNT_RST;
			pend_q <= 1'b0;
			rej_q <= 1'b0;
			conv_q <= 1'b1;
			core_q <= 1'b1;
			bias_q <= 1'b1;
		end else if (ce) begin
			cur_q <= cur_d;
			tgt_q <= tgt_d;
			cnt_q <= cnt_d;
			pend_q <= pend_d;
			rej_q <= rej_d;
			conv_q <= conv_d;
			core_q <= core_d;
			bias_q <= bias_d;
		end
	end

	// Outputs straight from flops; readback is actual state
	assign rd_state = cur_q;
	assign busy = pend_q;
	assign req_rejected = rej_q;
	assign conv_en = conv_q;
	assign core_pwr_en = core_q;
	assign bias_pwr_en = bias_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Assertion helpers: age of the accepted request in enabled cycles
	// A counter stands in for a long repetition, which the tools would unroll
	// It freezes with ce, so the latency is checked in enabled cycles only
	logic chk_take;
	logic [apsc_pkg::CNT_W-1:0] chk_age_q, chk_age_d;
	apsc_pkg::apsc_state_t chk_req_q, chk_req_d;
	apsc_pkg::apsc_state_t chk_old_q, chk_old_d;

	// Age 1 follows the taking edge; the change is due at age LAT_CNT + 1
	always_comb begin
		chk_take = wr_en && !pend_q && legal;
		chk_age_d = chk_age_q;
		chk_req_d = chk_req_q;
		chk_old_d = chk_old_q;
		if (chk_take) begin
			chk_age_d = 10'h001;
			chk_req_d = wr_state;
			chk_old_d = cur_q;
		end else if (chk_age_q == apsc_pkg::LAT_CNT + 10'h001) begin
			chk_age_d = apsc_pkg::CNT_RST;
		end else if (chk_age_q != apsc_pkg::CNT_RST) begin
			chk_age_d = chk_age_q + 10'h001;
		end
	end

	// Helper registers follow the same reset and enable as the design
	always_ff @(posedge clk) begin
		if (rst) begin
			chk_age_q <= apsc_pkg::CNT_RST;
			chk_req_q <= apsc_pkg::APSC_ACTIVE;
			chk_old_q <= apsc_pkg::APSC_ACTIVE;
		end else if (ce) begin
			chk_age_q <= chk_age_d;
			chk_req_q <= chk_req_d;
			chk_old_q <= chk_old_d;
		end
	end

	property p_one_state;
		cur_q inside {apsc_pkg::APSC_ACTIVE, apsc_pkg::APSC_PWRDN, apsc_pkg::APSC_STBY};
	endproperty
	a_one_state: assert property (p_one_state) else $error("illegal state");

	property p_pd_quiet;
		(rd_state == apsc_pkg::APSC_PWRDN) |-> (!conv_en && !bias_pwr_en && !core_pwr_en);
	endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("power-down not quiet");

	property p_sb_bias;
		(rd_state == apsc_pkg::APSC_STBY) |-> (!conv_en && bias_pwr_en);
	endproperty
	a_sb_bias: assert property (p_sb_bias) else $error("stand-by power wrong");

	property p_accept;
		(ce && wr_en && !pend_q && legal) |=> (busy && tgt_q == $past(wr_state));
	endproperty
	a_accept: assert property (p_accept) else $error("request not taken");

	property p_latency;
		(chk_age_q == apsc_pkg::LAT_CNT + 10'h001) |-> (rd_state == chk_req_q && !busy);
	endproperty
	a_latency: assert property (p_latency) else $error("latency not met");

	property p_early;
		(chk_age_q != apsc_pkg::CNT_RST && chk_age_q <= apsc_pkg::LAT_CNT) |->
			(busy && rd_state == chk_old_q);
	endproperty
	a_early: assert property (p_early) else $error("state changed too early");

	property p_illegal;
		(ce && wr_en && !pend_q && !legal) |=> (req_rejected && !busy && $stable(rd_state));
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal request taken");

	property p_hold;
		!busy |=> (rd_state == $past(rd_state));
	endproperty
	a_hold: assert property (p_hold) else $error("state moved while idle");

	property p_power_map;
		(conv_en == (rd_state == apsc_pkg::APSC_ACTIVE)) &&
			(core_pwr_en == (rd_state == apsc_pkg::APSC_ACTIVE)) &&
			(bias_pwr_en == (rd_state != apsc_pkg::APSC_PWRDN));
	endproperty
	a_power_map: assert property (p_power_map) else $error("power enables off state");

	property p_freeze;
		!ce |=> ($stable(rd_state) && $stable(busy) && $stable(req_rejected));
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with ce low");

	property p_rej_pulse;
		(req_rejected && ce && !wr_en) |=> !req_rejected;
	endproperty
	a_rej_pulse: assert property (p_rej_pulse) else $error("reject pulse too long");

	property p_reject;
		(ce && wr_en && pend_q) |=> (req_rejected && $stable(tgt_q));
	endproperty
	a_reject: assert property (p_reject) else $error("busy request not rejected");

	property p_no_pd_sb;
		(rd_state == apsc_pkg::APSC_PWRDN) |=> (rd_state != apsc_pkg::APSC_STBY);
	endproperty
	a_no_pd_sb: assert property (p_no_pd_sb) else $error("power-down to stand-by");

	c_to_pd: cover property (rd_state == apsc_pkg::APSC_PWRDN);
	c_to_sb: cover property (rd_state == apsc_pkg::APSC_STBY);
	c_rej: cover property (req_rejected);
	c_freeze: cover property (!ce && busy);
	c_pd_act_sb: cover property ((rd_state == apsc_pkg::APSC_PWRDN) ##[1:1000]
		(rd_state == apsc_pkg::APSC_ACTIVE) ##[1:1000] (rd_state == apsc_pkg::APSC_STBY));

endmodule // apsc_ctrl

// File: verilog/apsc_pkg.sv
// Package of constants and types for the power-state controller
package apsc_pkg;

	// ==========================================================
	// Power state encoding (codes chosen freely; code 2 stays unused)
	typedef enum logic [1:0] {
		APSC_ACTIVE = 2'h0,
		APSC_PWRDN = 2'h1,
		APSC_STBY = 2'h3
	} apsc_state_t;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 20000000;
	localparam int LAT_NS = 15000;
	// Shortest-style latency: round down, at least one cycle
	localparam int LAT_CYC = (LAT_NS / (1000000000 / CLK_HZ)) < 1 ? 1 :
		(LAT_NS / (1000000000 / CLK_HZ));
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] LAT_CNT = CNT_W'(LAT_CYC);
	localparam logic [CNT_W-1:0] CNT_RST = 10'h000;

endpackage

// File: verif/apsc_host.sv
// Host model that issues power state requests
`timescale 1ns/1ps
module apsc_host (
	// Clock
	input wire logic clk,
	// Request toward the controller
	output logic wr_en,
	output apsc_pkg::apsc_state_t wr_state
);
	// One-cycle strobe launched just after an edge, so the design never sees a race
	task automatic req(input apsc_pkg::apsc_state_t s);
		@(posedge clk);
		#1 wr_en = 1'b1;
		wr_state = s;
		@(posedge clk);
		#1 wr_en = 1'b0;
	endtask
	// Idle bus at time zero
	initial begin
		wr_en = 1'b0;
		wr_state = apsc_pkg::APSC_ACTIVE;
	end
endmodule // apsc_host

// File: verif/test_adc_power_state_control.sv
// Self-checking bench of the power-state controller
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
	$display("BAD %0t mismatch", $time); end end
module test_adc_power_state_control;
	// Signals and counters
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic wr_en, busy, req_rejected, conv_en, core_pwr_en, bias_pwr_en;
	apsc_pkg::apsc_state_t wr_state, rd_state;
	int fails = 0;
	int samples_checked = 0;
	int n;
	// ==========================================================
	// Clock and instances; ce is dropped by one scenario to check freezing
	always #25 clk = ~clk;
	apsc_host u_host (.clk(clk), .wr_en(wr_en), .wr_state(wr_state));
	apsc_ctrl u_dut (.clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en), .wr_state(wr_state),
		.rd_state(rd_state), .busy(busy), .req_rejected(req_rejected), .conv_en(conv_en),
		.core_pwr_en(core_pwr_en), .bias_pwr_en(bias_pwr_en));
	// ==========================================================
	// Verdict
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Accepted move: latency counted edge by edge, then the power controls
	task automatic go(input apsc_pkg::apsc_state_t s, input logic [2:0] en);
		u_host.req(s);
		@(posedge clk) #1;
		`CHK(busy, 1'b1)
		for (n = 1; n < 400 && rd_state !== s; n++) @(posedge clk) #1;
		`CHK(n, 300)
		`CHK(busy, 1'b0)
		if (n >= 400) stop_test();
		@(posedge clk) #1;
		`CHK({conv_en, core_pwr_en, bias_pwr_en}, en)
	endtask
	// Refused move: the pulse stands for the cycle after the taking edge only
	task automatic nak(input apsc_pkg::apsc_state_t s);
		apsc_pkg::apsc_state_t was;
		was = rd_state;
		u_host.req(s);
		`CHK(req_rejected, 1'b1)
		`CHK(rd_state, was)
		@(posedge clk) #1;
		`CHK(req_rejected, 1'b0)
	endtask
	// Frozen move: ce low holds the countdown, only enabled cycles count
	task automatic frz(input apsc_pkg::apsc_state_t s);
		apsc_pkg::apsc_state_t was;
		was = rd_state;
		u_host.req(s);
		ce = 1'b0;
		repeat (50) @(posedge clk) #1;
		`CHK(busy, 1'b1)
		`CHK(rd_state, was)
		ce = 1'b1;
		for (n = 0; n < 400 && rd_state !== s; n++) @(posedge clk) #1;
		`CHK(n, 300)
		if (n >= 400) stop_test();
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		`CHK(rd_state, apsc_pkg::APSC_ACTIVE)
		go(apsc_pkg::APSC_PWRDN, 3'h0);
		nak(apsc_pkg::APSC_STBY);
		nak(apsc_pkg::apsc_state_t'(2'h2));
		u_host.req(apsc_pkg::APSC_ACTIVE);
		nak(apsc_pkg::APSC_PWRDN);
		for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge clk) #1;
		`CHK(busy, 1'b0)
		if (n >= 400) stop_test();
		`CHK(rd_state, apsc_pkg::APSC_ACTIVE)
		go(apsc_pkg::APSC_STBY, 3'h1);
		go(apsc_pkg::APSC_ACTIVE, 3'h7);
		frz(apsc_pkg::APSC_PWRDN);
		stop_test();
	end
endmodule // test_adc_power_state_control
